// ===== design/ncr_pkg.sv
// package for the nand command/address/read host controller
// assumes a 10 MHz single clock; all types and constants shared by design files
package ncr_pkg;

    // ----------------------------------------
    // geometry and address cycles
    // ----------------------------------------
    localparam int PAGE_BYTES = 4352;
    localparam int MAIN_BYTES = 4096;
    localparam int SPARE_BYTES = 256;
    localparam logic [12:0] COL_MAX = 13'h10FF;
    localparam int ADDR_CYCLES = 5;
    localparam int COL_CYCLES = 2;

    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_START = 8'h30;
    localparam logic [7:0] CMD_COL_CHANGE = 8'h05;
    localparam logic [7:0] CMD_COL_CONFIRM = 8'hE0;
    localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_PROG_START = 8'h10;
    localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
    localparam logic [7:0] CMD_IN_COL_CHANGE = 8'h85;
    localparam logic [7:0] CMD_COPY_READ = 8'h3A;
    localparam logic [7:0] CMD_COPY_PROG = 8'h8C;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_START = 8'hD0;
    localparam logic [7:0] CMD_ID_READ = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
    localparam logic [7:0] CMD_RESET = 8'hFF;

    // ----------------------------------------
    // timing (strobe half period in cycles of 100 ns)
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int STROBE_NS = 100;
    localparam logic [3:0] STROBE_CYCLES = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int BUSY_WAIT_NS = 500; // covers busy onset through the three-stage synchroniser
    localparam logic [3:0] BUSY_WAIT_CYCLES = 4'((BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] RD_SETTLE_CYCLES = 3'h2; // extra low cycles so a byte crosses both io stages
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 8;

    // ----------------------------------------
    // request carrier and states
    // ----------------------------------------
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_COL_CHANGE = 3'h1,
        OP_CACHE_NEXT = 3'h2,
        OP_CACHE_LAST = 3'h3,
        OP_STATUS = 3'h4,
        OP_RESET = 3'h5,
        OP_CMD_ONLY = 3'h6
    } ncr_op_type;

    typedef struct packed {
        ncr_op_type op;
        logic [12:0] column_address;
        logic [5:0] page_in_block_address;
        logic [10:0] block_address;
        logic [7:0] raw_cmd;
        logic [12:0] length;
    } ncr_req_type;

    typedef struct packed {
        logic cle;
        logic ale;
        logic chip_enable_n;
        logic write_strobe_n;
        logic read_strobe_n;
    } ncr_pins_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_CMD1 = 4'h1,
        ST_ADDR = 4'h2,
        ST_CMD2 = 4'h3,
        ST_BUSY = 4'h4,
        ST_READ = 4'h5,
        ST_DONE = 4'h6
    } ncr_state_type;

endpackage

// ===== design/ncr_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module ncr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // ----------------------------------------
    // handshake and pointer update
    // ----------------------------------------
    always_comb begin
        in_ready = (cnt_q != (AW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = (AW+1)'(cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
        out_data = mem[rd_q];
    end

    // storage has no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointer registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

// ===== design/ncr_host.sv
// host controller driving a nand flash over its strobes and latch enables
// assumes clk at 10 MHz; ready_busy_n and io input come from pins
`timescale 1ns/1ps

// Summary of operation
// - full address goes out as five address latch cycles
// - column in cycle 1 and low 5 bits of cycle 2, top three low
// - page within block sits in low six bits of cycle 3
// - block bits 6..16; bit 16 on io bit 0 of cycle 5, rest low
// - chip enable low, read strobe high; write strobe rise latches cmd/addr/data
// - while device read-busy with chip enable low, keep both strobes high; status and reset requests are still issued and strobed while busy
// - page read is 00h, five address cycles, then 30h
// - column moves during output by 05h, two column cycles, E0h
module ncr_host (
    clk,
    arst_n,
    req,
    req_valid,
    req_ready,
    rd_data,
    rd_valid,
    rd_ready,
    busy,
    io_port_in,
    io_port_out,
    io_port_oe_n,
    pins,
    write_protect_n,
    ready_busy_n
);
    input wire logic clk;
    input wire logic arst_n;
    input wire ncr_pkg::ncr_req_type req;
    input wire logic req_valid;
    output logic req_ready;
    output logic [7:0] rd_data;
    output logic rd_valid;
    input wire logic rd_ready;
    output logic busy;
    input wire logic [7:0] io_port_in;
    output logic [7:0] io_port_out;
    output logic io_port_oe_n;
    output ncr_pkg::ncr_pins_type pins;
    output logic write_protect_n;
    input wire logic ready_busy_n;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] rb_sync_q;
    logic rb_q;
    logic [7:0] io_s1_q, io_s2_q;

    // three stages; change accepted when stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rb_sync_q <= 3'h7;
            rb_q <= 1'b1;
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
        end else begin
            rb_sync_q <= {rb_sync_q[1:0], ready_busy_n};
            if (rb_sync_q[1] == rb_sync_q[2]) begin
                rb_q <= rb_sync_q[2];
            end
            io_s1_q <= io_port_in;
            io_s2_q <= io_s1_q;
        end
    end

    // ----------------------------------------
    // address cycle encoding
    // ----------------------------------------
    function automatic logic [7:0] addr_byte(input ncr_pkg::ncr_req_type r, input logic [2:0] idx);
        logic [16:0] row;
        row = {r.block_address, r.page_in_block_address};
        case (idx)
            3'h0: addr_byte = r.column_address[7:0];
            3'h1: addr_byte = {3'h0, r.column_address[12:8]};
            3'h2: addr_byte = row[7:0];
            3'h3: addr_byte = row[15:8];
            3'h4: addr_byte = {7'h00, row[16]};
            default: addr_byte = 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    ncr_pkg::ncr_state_type st_q, st_d;
    ncr_pkg::ncr_req_type r_q, r_d;
    logic [2:0] idx_q, idx_d;
    logic [3:0] tmr_q, tmr_d;
    logic ph_q, ph_d;
    logic [12:0] cnt_q, cnt_d;
    ncr_pkg::ncr_pins_type pins_q, pins_d;
    logic [7:0] dout_q, dout_d;
    logic oe_n_q, oe_n_d;
    logic [7:0] fin_data;
    logic fin_valid, fin_ready;
    logic tick;
    logic [2:0] n_addr;

    // strobe phase timer: tick once per half period
    assign tick = (tmr_q == ncr_pkg::STROBE_CYCLES - 4'h1);
    assign req_ready = (st_q == ncr_pkg::ST_IDLE);
    assign busy = (st_q != ncr_pkg::ST_IDLE) || !rb_q;

    always_comb begin
        st_d = st_q;
        r_d = r_q;
        idx_d = idx_q;
        tmr_d = tick ? 4'h0 : 4'(tmr_q + 4'h1);
        ph_d = ph_q;
        cnt_d = cnt_q;
        pins_d = pins_q;
        dout_d = dout_q;
        oe_n_d = oe_n_q;
        fin_data = io_s2_q;
        fin_valid = 1'b0;
        n_addr = (r_q.op == ncr_pkg::OP_COL_CHANGE) ? 3'(ncr_pkg::COL_CYCLES) : 3'(ncr_pkg::ADDR_CYCLES);
        case (st_q)
            ncr_pkg::ST_IDLE: begin
                pins_d = '{cle: 1'b0, ale: 1'b0, chip_enable_n: 1'b1, write_strobe_n: 1'b1, read_strobe_n: 1'b1};
                oe_n_d = 1'b1;
                ph_d = 1'b0;
                tmr_d = 4'h0;
                // only reset and status may be issued while the device is busy
                if (req_valid && (rb_q || req.op == ncr_pkg::OP_STATUS || req.op == ncr_pkg::OP_RESET)) begin
                    r_d = req;
                    idx_d = 3'h0;
                    cnt_d = 13'h0000;
                    pins_d.chip_enable_n = 1'b0;
                    st_d = ncr_pkg::ST_CMD1;
                end
            end
            ncr_pkg::ST_CMD1: begin
                // first command cycle: cle high, write strobe low then rising
                if (tick) begin
                    if (!ph_q) begin
                        pins_d.cle = 1'b1;
                        pins_d.write_strobe_n = 1'b0;
                        oe_n_d = 1'b0;
                        case (r_q.op)
                            ncr_pkg::OP_READ: dout_d = ncr_pkg::CMD_READ_SETUP;
                            ncr_pkg::OP_COL_CHANGE: dout_d = ncr_pkg::CMD_COL_CHANGE;
                            ncr_pkg::OP_CACHE_NEXT: dout_d = ncr_pkg::CMD_CACHE_NEXT;
                            ncr_pkg::OP_CACHE_LAST: dout_d = ncr_pkg::CMD_CACHE_LAST;
                            ncr_pkg::OP_STATUS: dout_d = ncr_pkg::CMD_STATUS;
                            ncr_pkg::OP_RESET: dout_d = ncr_pkg::CMD_RESET;
                            default: dout_d = r_q.raw_cmd;
                        endcase
                        ph_d = 1'b1;
                    end else begin
                        // cle and the byte stay put across the rising strobe
                        pins_d.write_strobe_n = 1'b1;
                        ph_d = 1'b0;
                        case (r_q.op)
                            ncr_pkg::OP_READ, ncr_pkg::OP_COL_CHANGE: st_d = ncr_pkg::ST_ADDR;
                            ncr_pkg::OP_STATUS: st_d = ncr_pkg::ST_READ;
                            ncr_pkg::OP_CMD_ONLY: st_d = ncr_pkg::ST_DONE;
                            default: st_d = ncr_pkg::ST_BUSY;
                        endcase
                        if (r_q.op == ncr_pkg::OP_STATUS) begin
                            r_d.length = 13'h0001;
                        end
                    end
                end
            end
            ncr_pkg::ST_ADDR: begin
                // address cycles: ale high, one byte per write strobe
                if (tick) begin
                    if (!ph_q) begin
                        pins_d.cle = 1'b0;
                        pins_d.ale = 1'b1;
                        pins_d.write_strobe_n = 1'b0;
                        oe_n_d = 1'b0;
                        dout_d = addr_byte(r_q, idx_q);
                        ph_d = 1'b1;
                    end else begin
                        pins_d.write_strobe_n = 1'b1;
                        ph_d = 1'b0;
                        idx_d = 3'(idx_q + 3'h1);
                        if (idx_q == 3'(n_addr - 3'h1)) begin
                            st_d = ncr_pkg::ST_CMD2; // ale held through the last rise
                        end
                    end
                end
            end
            ncr_pkg::ST_CMD2: begin
                // confirm command starts the transfer or the column move
                if (tick) begin
                    if (!ph_q) begin
                        pins_d.ale = 1'b0;
                        pins_d.cle = 1'b1;
                        pins_d.write_strobe_n = 1'b0;
                        oe_n_d = 1'b0;
                        dout_d = (r_q.op == ncr_pkg::OP_COL_CHANGE) ?
                            ncr_pkg::CMD_COL_CONFIRM : ncr_pkg::CMD_READ_START;
                        ph_d = 1'b1;
                    end else begin
                        pins_d.write_strobe_n = 1'b1;
                        ph_d = 1'b0;
                        st_d = (r_q.op == ncr_pkg::OP_COL_CHANGE) ? ncr_pkg::ST_READ : ncr_pkg::ST_BUSY;
                    end
                end
            end
            ncr_pkg::ST_BUSY: begin
                // strobes stay high; wait for busy to appear and clear
                pins_d.write_strobe_n = 1'b1;
                pins_d.read_strobe_n = 1'b1;
                pins_d.cle = 1'b0;
                oe_n_d = 1'b1;
                if (cnt_q < 13'(ncr_pkg::BUSY_WAIT_CYCLES)) begin
                    cnt_d = 13'(cnt_q + 13'h0001);
                end else if (rb_q) begin
                    cnt_d = 13'h0000;
                    tmr_d = 4'h0;
                    st_d = (r_q.op == ncr_pkg::OP_RESET) ? ncr_pkg::ST_DONE : ncr_pkg::ST_READ;
                end
            end
            ncr_pkg::ST_READ: begin
                // serial output: strobe stays low until the byte has crossed both io stages
                pins_d.cle = 1'b0;
                oe_n_d = 1'b1;
                if (cnt_q == r_q.length) begin
                    st_d = ncr_pkg::ST_DONE;
                end else if (tick && fin_ready) begin
                    if (!ph_q) begin
                        pins_d.read_strobe_n = 1'b0;
                        idx_d = 3'h0;
                        ph_d = 1'b1;
                    end else if (idx_q != ncr_pkg::RD_SETTLE_CYCLES) begin
                        idx_d = 3'(idx_q + 3'h1);
                    end else begin
                        fin_valid = 1'b1;
                        pins_d.read_strobe_n = 1'b1;
                        ph_d = 1'b0;
                        cnt_d = 13'(cnt_q + 13'h0001);
                    end
                end
            end
            ncr_pkg::ST_DONE: begin
                pins_d.chip_enable_n = 1'b1;
                pins_d.cle = 1'b0;
                oe_n_d = 1'b1;
                st_d = ncr_pkg::ST_IDLE;
            end
            default: st_d = ncr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ncr_pkg::ST_IDLE;
            r_q <= '0;
            idx_q <= 3'h0;
            tmr_q <= 4'h0;
            ph_q <= 1'b0;
            cnt_q <= 13'h0000;
            pins_q <= '{cle: 1'b0, ale: 1'b0, chip_enable_n: 1'b1, write_strobe_n: 1'b1, read_strobe_n: 1'b1};
            dout_q <= 8'h00;
            oe_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            r_q <= r_d;
            idx_q <= idx_d;
            tmr_q <= tmr_d;
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign pins = pins_q;
    assign io_port_out = dout_q;
    assign io_port_oe_n = oe_n_q;
    assign write_protect_n = 1'b0;

    // ----------------------------------------
    // read data fifo
    // ----------------------------------------
    ncr_fifo #(
        .WIDTH(ncr_pkg::FIFO_WIDTH),
        .DEPTH(ncr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_data(fin_data),
        .in_valid(fin_valid),
        .in_ready(fin_ready),
        .out_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready)
    );
endmodule

// ===== sim/ncr_host_sva.sv
// checker on the nand host controller ports
// assumes binding onto ncr_host; one clock, async active-low reset
`timescale 1ns/1ps
module ncr_host_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire ncr_pkg::ncr_req_type req,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic busy,
    input wire logic [7:0] io_port_in,
    input wire logic [7:0] io_port_out,
    input wire logic io_port_oe_n,
    input wire ncr_pkg::ncr_pins_type pins,
    input wire logic write_protect_n,
    input wire logic ready_busy_n
);
    logic [2:0] n_q;
    logic [2:0] n_d;
    logic we_lo;
    assign we_lo = !pins.write_strobe_n;
    // address bytes since the last command latch
    always_comb begin
        n_d = n_q;
        if (we_lo && pins.cle) n_d = 3'h0;
        else if (we_lo && pins.ale) n_d = n_q + 3'h1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) n_q <= 3'h0;
        else n_q <= n_d;
    end
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_excl; !(pins.cle && pins.ale); endproperty
    a_excl: assert property (p_excl) else $error("both latches high");
    property p_we_ctx; we_lo |-> !pins.chip_enable_n && pins.read_strobe_n && !io_port_oe_n; endproperty
    a_we_ctx: assert property (p_we_ctx) else $error("write strobe out of context");
    property p_we_one; $fell(pins.write_strobe_n) |=> pins.write_strobe_n; endproperty
    a_we_one: assert property (p_we_one) else $error("write strobe low too long");
    property p_re_ctx; !pins.read_strobe_n |-> io_port_oe_n && !pins.cle && !pins.ale; endproperty
    a_re_ctx: assert property (p_re_ctx) else $error("host drives during output");
    property p_col_hi; we_lo && pins.ale && n_q == 3'h1 |-> io_port_out[7:5] == 3'h0; endproperty
    a_col_hi: assert property (p_col_hi) else $error("column high bits set");
    property p_row_hi; we_lo && pins.ale && n_q == 3'h4 |-> io_port_out[7:1] == 7'h00; endproperty
    a_row_hi: assert property (p_row_hi) else $error("fifth cycle high bits set");
    property p_start; we_lo && pins.cle && io_port_out == ncr_pkg::CMD_READ_START |-> n_q == 3'h5; endproperty
    a_start: assert property (p_start) else $error("read start without five bytes");
    property p_conf; we_lo && pins.cle && io_port_out == ncr_pkg::CMD_COL_CONFIRM |-> n_q == 3'h2; endproperty
    a_conf: assert property (p_conf) else $error("column confirm without two bytes");
    property p_quiet; !ready_busy_n [*3] |-> pins.write_strobe_n && pins.read_strobe_n; endproperty
    a_quiet: assert property (p_quiet) else $error("strobe while device busy");
    property p_wp; write_protect_n == 1'b0; endproperty
    a_wp: assert property (p_wp) else $error("write protect released");
    c_start: cover property (we_lo && pins.cle && io_port_out == ncr_pkg::CMD_READ_START);
    c_conf: cover property (we_lo && pins.cle && io_port_out == ncr_pkg::CMD_COL_CONFIRM);
    c_pop: cover property (rd_valid && rd_ready);
    c_busy: cover property (!ready_busy_n && busy);
endmodule
bind ncr_host ncr_host_sva u_sva (.clk(clk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .busy(busy),
    .io_port_in(io_port_in), .io_port_out(io_port_out), .io_port_oe_n(io_port_oe_n), .pins(pins),
    .write_protect_n(write_protect_n), .ready_busy_n(ready_busy_n));

// ===== sim/ncr_dev_model.sv
// behavioural nand device: latches, busy timer, serial output
// assumes registered host pins; resolves the shared io bus itself
`timescale 1ns/1ps
module ncr_dev_model (
    input wire logic clk,
    input wire ncr_pkg::ncr_pins_type pins,
    input wire logic [7:0] host_out,
    input wire logic host_oe_n,
    input wire logic [7:0] busy_len,
    output logic [7:0] io_wire,
    output logic ready_busy_n,
    output logic [12:0] col_q,
    output logic [16:0] row_q,
    output logic [7:0] cmd_q
);
    logic [7:0] dout = 8'h00;
    logic [39:0] addr_q = 40'h0;
    logic drv = 1'b0;
    logic stat = 1'b0;
    int n = 0;
    event go;
    // released bus shows the inverse of the last byte
    assign io_wire = !host_oe_n ? host_out : (drv ? dout : ~dout);
    initial begin
        ready_busy_n = 1'b1;
        cmd_q = ncr_pkg::CMD_READ_SETUP;
        col_q = 13'h0000;
        row_q = 17'h00000;
    end
    // ----------------------------------------
    // latch and decode
    // ----------------------------------------
    always @(posedge pins.write_strobe_n) begin
        if (!pins.chip_enable_n && pins.read_strobe_n && pins.ale && !pins.cle && n < 5) begin
            addr_q[8*n +: 8] = io_wire;
            n = n + 1;
        end
        if (!pins.chip_enable_n && pins.read_strobe_n && pins.cle && !pins.ale && (ready_busy_n ||
            io_wire inside {ncr_pkg::CMD_RESET, ncr_pkg::CMD_STATUS, ncr_pkg::CMD_STATUS_MULTI})) begin
            stat = 1'b0;
            case (io_wire)
                ncr_pkg::CMD_READ_SETUP, ncr_pkg::CMD_COL_CHANGE: begin
                    cmd_q = io_wire;
                    n = 0;
                end
                ncr_pkg::CMD_READ_START: begin
                    col_q = addr_q[12:0];
                    row_q = addr_q[32:16];
                    ->go;
                end
                ncr_pkg::CMD_COL_CONFIRM: col_q = addr_q[12:0];
                ncr_pkg::CMD_CACHE_NEXT, ncr_pkg::CMD_CACHE_LAST: begin
                    row_q = row_q + 17'h00001;
                    col_q = 13'h0000;
                    ->go;
                end
                ncr_pkg::CMD_STATUS, ncr_pkg::CMD_STATUS_MULTI: stat = 1'b1;
                ncr_pkg::CMD_RESET: begin
                    cmd_q = ncr_pkg::CMD_READ_SETUP;
                    ->go;
                end
                default: ;
            endcase
        end
    end
    // busy period, chip enable ignored meanwhile
    always @(go) begin
        ready_busy_n = 1'b0;
        repeat (busy_len) @(posedge clk);
        ready_busy_n = 1'b1;
    end
    // one byte per read strobe fall, column advances except after a status command
    always @(negedge pins.read_strobe_n) begin
        if (!pins.chip_enable_n && ready_busy_n) begin
            dout = stat ? 8'hE0 : (col_q[7:0] ^ row_q[7:0] ^ 8'h5A);
            drv = 1'b1;
            if (!stat) col_q = col_q + 13'h0001;
        end
    end
    // release after the output hold time
    always @(posedge pins.read_strobe_n) begin
        #25;
        drv = 1'b0;
    end
endmodule

// ===== sim/test_nand_command_address_read.sv
// self-checking bench for the nand host controller
// assumes ncr_dev_model on the pins; checker bound separately
`timescale 1ns/1ps
module test_nand_command_address_read;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    ncr_pkg::ncr_req_type req = '0;
    logic req_valid = 1'b0;
    logic rd_ready = 1'b0;
    logic stall = 1'b0;
    logic [7:0] busy_len = 8'h02;
    logic req_ready, rd_valid, busy, io_port_oe_n, write_protect_n, ready_busy_n;
    logic [7:0] rd_data, io_port_out, io_wire, cmd_q;
    ncr_pkg::ncr_pins_type pins;
    logic [12:0] col_q;
    logic [16:0] row_q;
    logic [31:0] seed = 32'h00000008;
    logic [7:0] got[$];
    int fails = 0;
    int n_compared = 0;
    ncr_host dut_u (.clk(clk), .arst_n(arst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .busy(busy), .io_port_in(io_wire),
        .io_port_out(io_port_out), .io_port_oe_n(io_port_oe_n), .pins(pins),
        .write_protect_n(write_protect_n), .ready_busy_n(ready_busy_n));
    ncr_dev_model u_dev (.clk(clk), .pins(pins), .host_out(io_port_out), .host_oe_n(io_port_oe_n),
        .busy_len(busy_len), .io_wire(io_wire), .ready_busy_n(ready_busy_n), .col_q(col_q),
        .row_q(row_q), .cmd_q(cmd_q));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] exp_byte(logic [12:0] c, logic [16:0] r);
        return c[7:0] ^ r[7:0] ^ 8'h5A;
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // issue one request, optionally stall the reader, then compare
    task automatic run(ncr_pkg::ncr_op_type op, logic [12:0] c, logic [16:0] r, logic [7:0] raw,
        logic [12:0] len, int hold, logic [12:0] ec, logic [16:0] er, int en);
        int i;
        stall = hold > 0;
        @(posedge clk);
        #1;
        req = '{op, c, r[5:0], r[16:6], raw, len};
        req_valid = 1'b1;
        for (i = 0; i < 50 && busy !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        req_valid = 1'b0;
        if (busy !== 1'b1) begin
            fails++;
            finish_test();
        end
        repeat (hold) @(posedge clk);
        if (hold > 0) check({busy, rd_valid}, 2'b11);
        stall = 1'b0;
        for (i = 0; i < 20000 && (busy !== 1'b0 || rd_valid !== 1'b0); i++) @(posedge clk);
        if (i == 20000) begin
            fails++;
            finish_test();
        end
        check(got.size(), en);
        for (i = 0; i < got.size(); i++)
            check(got[i], op == ncr_pkg::OP_STATUS ? 8'hE0 : exp_byte(13'(ec + i), er));
        check(row_q, er);
        if (op != ncr_pkg::OP_STATUS) check(col_q, 13'(ec + en));
        got.delete();
    endtask
    // ----------------------------------------
    // clock, reader, stimulus
    // ----------------------------------------
    initial forever #50 clk = ~clk;
    // random reader back-pressure
    always @(posedge clk) begin
        #1;
        rd_ready = !stall && (rnd() % 4 != 0);
    end
    // collect popped bytes
    always @(posedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
    initial begin
        int i;
        int l;
        logic [12:0] c;
        logic [16:0] r;
        logic [7:0] raws[5];
        raws = '{8'hC3, ncr_pkg::CMD_ERASE_SETUP, ncr_pkg::CMD_PROG_SETUP, ncr_pkg::CMD_IN_COL_CHANGE,
            ncr_pkg::CMD_COPY_PROG};
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        // random reads with prompt and slow busy
        for (i = 0; i < 4; i++) begin
            c = 13'(rnd() % 4000);
            r = 17'(rnd());
            l = 1 + rnd() % 8;
            busy_len = 8'(2 + rnd() % 20);
            run(ncr_pkg::OP_READ, c, r, 8'h00, 13'(l), 0, c, r, l);
        end
        run(ncr_pkg::OP_READ, ncr_pkg::COL_MAX, 17'h1FFFF, 8'h00, 13'h1, 0, ncr_pkg::COL_MAX, 17'h1FFFF, 1);
        run(ncr_pkg::OP_READ, 13'h0010, r, 8'h00, 13'hC, 60, 13'h0010, r, 12);
        c = 13'(rnd() % 4000);
        run(ncr_pkg::OP_COL_CHANGE, c, r, 8'h00, 13'h4, 0, c, r, 4);
        run(ncr_pkg::OP_CACHE_NEXT, 13'h0, r, 8'h00, 13'h3, 0, 13'h0, 17'(r + 1), 3);
        run(ncr_pkg::OP_CACHE_LAST, 13'h0, r, 8'h00, 13'h2, 0, 13'h0, 17'(r + 2), 2);
        run(ncr_pkg::OP_STATUS, 13'h0, r, 8'h00, 13'h1, 0, 13'h0, 17'(r + 2), 1);
        run(ncr_pkg::OP_RESET, 13'h0, r, 8'h00, 13'h0, 0, 13'h2, 17'(r + 2), 0);
        check(cmd_q, ncr_pkg::CMD_READ_SETUP);
        for (i = 0; i < 5; i++)
            run(ncr_pkg::OP_CMD_ONLY, 13'h0, r, raws[i], 13'h0, 0, 13'h2, 17'(r + 2), 0);
        finish_test();
    end
endmodule
